// file: src/lcig_top.sv
`timescale 1ns/100ps
//
// Operation
// - Cell two selector three picks ccp3 event, ccp2 event, ccp2 output, UART2 RX, SPI2 SDO, comparator 2, own output or pin A by code 7 down to 0.
// - Cell one selector two in bits 6-4 picks ccp1 event, EOC, UART1 TX, comparator 1, cell two output or pin B, with 7 and 5 reserved.
// - Cell two selector two picks the same set with UART2 TX and cell one output.
// - Selector one in bits 2-0 picks ccp1 outputs C/B/A, reference clock, low-power RC clock, secondary oscillator clock, system clock or pin A.
// - Gate four enables sit in bits 31-24, source four true down to source one inverted.
// - Gate three enables sit in bits 23-16 in the same order.
// - Gate two enables sit in bits 15-8 in the same order.
// - Gate one enables sit in bits 7-0 in the same order.
// - A set true enable feeds the source uninverted into its gate.
// - A set inverted enable feeds the complemented source into its gate.
// - A cleared enable keeps that form out, and all enable bits are independent and writable.
// - A set gate polarity bit in control bits 19-16 inverts that gate output.
// - With control bit 15 clear the cell drives zero on its outputs.
module lcig_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire lcig_pkg::lcig_async_t src_async,
    input wire lcig_pkg::lcig_event_t src_event,
    output logic [7:0] gate_out,
    output logic [1:0] cell_out
);
    import lcig_pkg::*;

    // ==========================================================
    // Selector functions
    // ==========================================================
    function automatic logic sel_one(
        input logic [2:0] code,
        input logic pin_a,
        input logic fsys,
        input lcig_async_t a,
        input lcig_event_t e
    );
        logic r;
        r = 1'b0;
        unique case (code)
            CODE_7: r = e.multi_ccp_output_c;
            CODE_6: r = e.multi_ccp_output_b;
            CODE_5: r = e.multi_ccp_output_a;
            CODE_4: r = a.reference_clock_output;
            CODE_3: r = a.low_power_rc_clock;
            CODE_2: r = a.secondary_oscillator_clock;
            CODE_1: r = fsys;
            CODE_0: r = pin_a;
        endcase
        return r;
    endfunction : sel_one

    function automatic logic sel_two(
        input logic [2:0] code,
        input logic pin_b,
        input logic uart_tx,
        input logic other_cell,
        input lcig_async_t a,
        input lcig_event_t e
    );
        logic r;
        r = 1'b0;
        unique case (code)
            CODE_7: r = 1'b0; // Reserved
            CODE_6: r = e.multi_ccp_event;
            CODE_5: r = 1'b0; // Reserved
            CODE_4: r = e.adc_end_of_conversion;
            CODE_3: r = uart_tx;
            CODE_2: r = a.comparator_one;
            CODE_1: r = other_cell;
            CODE_0: r = pin_b;
        endcase
        return r;
    endfunction : sel_two

    // ==========================================================
    // Input synchroniser
    // ==========================================================
    logic [ASYNC_W-1:0] async_meta;
    logic [ASYNC_W-1:0] async_sync;
    lcig_async_t a_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            async_meta <= '0;
            async_sync <= '0;
        end else begin
            async_meta <= src_async;
            async_sync <= async_meta;
        end
    end
    assign a_s = async_sync;

    // System clock as data: a half-rate toggle
    logic fsys_tog;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fsys_tog <= 1'b0;
        end else begin
            fsys_tog <= ~fsys_tog;
        end
    end

    // ==========================================================
    // AHB-Lite slave
    // ==========================================================
    logic [31:0] ctrl [2];
    logic [31:0] sel [2];
    logic [31:0] gls [2];
    logic [31:0] next_ctrl [2];
    logic [31:0] next_sel [2];
    logic [31:0] next_gls [2];
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_ok;
    logic [31:0] rd_val;

    assign addr_ok = hsel & hready & (htrans == TRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok & hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Write lands at the end of the data phase
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            next_ctrl[c] = ctrl[c];
            next_sel[c] = sel[c];
            next_gls[c] = gls[c];
            if (wr_pend && wr_addr[7:5] == 3'h0
                    && wr_addr[4] == c[0]) begin
                unique case (wr_addr[3:0])
                    CTRL_OFS[3:0]: next_ctrl[c] = hwdata & CTRL_MASK;
                    SEL_OFS[3:0]: next_sel[c] = hwdata & SEL_MASK;
                    GLS_OFS[3:0]: next_gls[c] = hwdata & GLS_MASK;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < 2; c++) begin
                ctrl[c] <= CTRL_RESET;
                sel[c] <= SEL_RESET;
                gls[c] <= GLS_RESET;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                ctrl[c] <= next_ctrl[c];
                sel[c] <= next_sel[c];
                gls[c] <= next_gls[c];
            end
        end
    end

    // Read mux sees a write completing in the same edge
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (haddr[7:0])
            CTRL1_ADDR: rd_val = next_ctrl[0] | ({31'h0, cell_out[0]}
                << CTRL_OUT_BIT);
            SEL1_ADDR: rd_val = next_sel[0];
            GLS1_ADDR: rd_val = next_gls[0];
            CTRL2_ADDR: rd_val = next_ctrl[1] | ({31'h0, cell_out[1]}
                << CTRL_OUT_BIT);
            SEL2_ADDR: rd_val = next_sel[1];
            GLS2_ADDR: rd_val = next_gls[1];
            STAT_OFS: rd_val = {22'h0, cell_out, gate_out};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            if (addr_ok && !hwrite) begin
                hrdata <= rd_val;
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ==========================================================
    // Data selection
    // ==========================================================
    logic [3:0] data_c1;
    logic [3:0] data_c2;
    logic [2:0] s3;

    always_comb begin
        data_c1[0] = sel_one(sel[0][SEL_ONE_LSB +: 3],
            a_s.cell_input_pin_a[0], fsys_tog, a_s, src_event);
        data_c2[0] = sel_one(sel[1][SEL_ONE_LSB +: 3],
            a_s.cell_input_pin_a[1], fsys_tog, a_s, src_event);
        data_c1[1] = sel_two(sel[0][SEL_TWO_LSB +: 3],
            a_s.cell_input_pin_b[0], src_event.uart_one_tx,
            cell_out[1], a_s, src_event);
        data_c2[1] = sel_two(sel[1][SEL_TWO_LSB +: 3],
            a_s.cell_input_pin_b[1], src_event.uart_two_tx,
            cell_out[0], a_s, src_event);
        // Cell one selector three and both selector fours are absent
        data_c1[2] = 1'b0;
        data_c1[3] = 1'b0;
        data_c2[3] = 1'b0;
        s3 = sel[1][SEL_THREE_LSB +: 3];
        unique case (s3)
            CODE_7: data_c2[2] = src_event.single_ccp_three_event;
            CODE_6: data_c2[2] = src_event.single_ccp_two_event;
            CODE_5: data_c2[2] = src_event.single_ccp_two_output;
            CODE_4: data_c2[2] = a_s.uart_two_rx;
            CODE_3: data_c2[2] = src_event.spi_two_sdo;
            CODE_2: data_c2[2] = a_s.comparator_two;
            CODE_1: data_c2[2] = cell_out[1];
            CODE_0: data_c2[2] = a_s.cell_input_pin_a[1];
        endcase
    end

    // ==========================================================
    // Gating and outputs
    // ==========================================================
    logic [3:0] gate_c1;
    logic [3:0] gate_c2;

    lcig_gate u_gate_c1 (
        .data(data_c1),
        .enables(gls[0]),
        .invert(ctrl[0][CTRL_POL_LSB +: 4]),
        .enable(ctrl[0][CTRL_EN_BIT]),
        .gate(gate_c1)
    );

    lcig_gate u_gate_c2 (
        .data(data_c2),
        .enables(gls[1]),
        .invert(ctrl[1][CTRL_POL_LSB +: 4]),
        .enable(ctrl[1][CTRL_EN_BIT]),
        .gate(gate_c2)
    );

    // Cell output: OR of gates, a stand-in for the cell logic modes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_out <= 8'h00;
            cell_out <= 2'h0;
        end else begin
            gate_out <= {gate_c2, gate_c1};
            cell_out <= {|gate_c2, |gate_c1};
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence gls1_write_s;
        wr_pend && wr_addr == GLS1_ADDR;
    endsequence

    sequence c1_plain_s;
        ctrl[0][CTRL_EN_BIT] && ctrl[0][CTRL_POL_LSB +: 4] == 4'h0;
    endsequence

    cell_off_zero_a: assert property (!ctrl[0][CTRL_EN_BIT]
        |=> gate_out[3:0] == 4'h0 && !cell_out[0])
        else $error("disabled cell drove a gate");
    no_enable_zero_a: assert property (c1_plain_s and gls[0][7:0] == 8'h00
        |=> !gate_out[0])
        else $error("gate high with no enable");
    true_feed_a: assert property (c1_plain_s and gls[0][7:0] == 8'h02
        |=> gate_out[0] == $past(data_c1[0]))
        else $error("true form not passed");
    inv_feed_a: assert property (c1_plain_s and gls[0][7:0] == 8'h01
        |=> gate_out[0] == !$past(data_c1[0]))
        else $error("inverted form not passed");
    gate_polarity_a: assert property (ctrl[0][CTRL_EN_BIT]
        && ctrl[0][CTRL_POL_LSB] && gls[0][7:0] == 8'h00
        |=> gate_out[0])
        else $error("gate polarity not applied");
    gate_four_a: assert property (ctrl[1][CTRL_EN_BIT]
        && ctrl[1][CTRL_POL_LSB +: 4] == 4'h0
        && gls[1][31:24] == 8'h02
        |=> gate_out[7] == $past(data_c2[0]))
        else $error("gate four layout wrong");
    gate_three_a: assert property (c1_plain_s
        and gls[0][23:16] == 8'h40
        |=> gate_out[2] == !$past(data_c1[3]))
        else $error("gate three layout wrong");
    gate_two_a: assert property (c1_plain_s and gls[0][15:8] == 8'h01
        |=> gate_out[1] == !$past(data_c1[0]))
        else $error("gate two layout wrong");
    gate_one_a: assert property (c1_plain_s and gls[0][7:0] == 8'h08
        |=> gate_out[0] == $past(data_c1[1]))
        else $error("gate one layout wrong");
    enable_write_a: assert property (gls1_write_s
        |=> gls[0] == $past(hwdata) ##1 (gls[0] == $past(gls[0])
        || $past(wr_pend && wr_addr == GLS1_ADDR)))
        else $error("gate enables not written");
    sel_one_a: assert property (sel[0][2:0] == CODE_1
        |-> data_c1[0] == fsys_tog)
        else $error("selector one wrong");
    sel_two_a: assert property (sel[0][6:4] == CODE_1
        |-> data_c1[1] == cell_out[1])
        else $error("cell one selector two wrong");
    sel_two_c2_a: assert property (sel[1][6:4] == CODE_3
        |-> data_c2[1] == src_event.uart_two_tx)
        else $error("cell two selector two wrong");
    sel_three_a: assert property (sel[1][10:8] == CODE_4
        |-> data_c2[2] == a_s.uart_two_rx)
        else $error("cell two selector three wrong");
    reserved_zero_a: assert property (sel[0][6:4] == CODE_7
        || sel[0][6:4] == CODE_5 |-> !data_c1[1])
        else $error("reserved code not zero");
endmodule : lcig_top

// file: src/lcig_pkg.sv
package lcig_pkg;
    // ==========================================================
    // Register map, byte addresses within the block
    // ==========================================================
    localparam logic [7:0] CELL_STRIDE = 8'h10;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SEL_OFS = 8'h04;
    localparam logic [7:0] GLS_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h20;
    localparam logic [7:0] CTRL1_ADDR = 8'h00;
    localparam logic [7:0] SEL1_ADDR = 8'h04;
    localparam logic [7:0] GLS1_ADDR = 8'h08;
    localparam logic [7:0] CTRL2_ADDR = 8'h10;
    localparam logic [7:0] SEL2_ADDR = 8'h14;
    localparam logic [7:0] GLS2_ADDR = 8'h18;

    // ==========================================================
    // Field positions, writable masks and reset values
    // ==========================================================
    localparam int CTRL_EN_BIT = 15;
    localparam int CTRL_POL_LSB = 16;
    localparam int CTRL_OUT_BIT = 6;
    localparam int SEL_ONE_LSB = 0;
    localparam int SEL_TWO_LSB = 4;
    localparam int SEL_THREE_LSB = 8;
    localparam int GATE_BYTE_W = 8;
    localparam logic [31:0] CTRL_MASK = 32'h000F_8000;
    localparam logic [31:0] SEL_MASK = 32'h0000_7777;
    localparam logic [31:0] GLS_MASK = 32'hFFFF_FFFF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] GLS_RESET = 32'h0000_0000;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;

    // ==========================================================
    // Selector codes
    // ==========================================================
    localparam logic [2:0] CODE_0 = 3'h0;
    localparam logic [2:0] CODE_1 = 3'h1;
    localparam logic [2:0] CODE_2 = 3'h2;
    localparam logic [2:0] CODE_3 = 3'h3;
    localparam logic [2:0] CODE_4 = 3'h4;
    localparam logic [2:0] CODE_5 = 3'h5;
    localparam logic [2:0] CODE_6 = 3'h6;
    localparam logic [2:0] CODE_7 = 3'h7;

    // ==========================================================
    // Source carriers
    // ==========================================================
    // Pins, comparators and foreign clocks: synchronised inside
    typedef struct packed {
        logic [1:0] cell_input_pin_a;
        logic [1:0] cell_input_pin_b;
        logic reference_clock_output;
        logic low_power_rc_clock;
        logic secondary_oscillator_clock;
        logic comparator_one;
        logic comparator_two;
        logic uart_two_rx;
    } lcig_async_t;

    // Peripheral signals already on hclk
    typedef struct packed {
        logic multi_ccp_event;
        logic multi_ccp_output_a;
        logic multi_ccp_output_b;
        logic multi_ccp_output_c;
        logic single_ccp_two_event;
        logic single_ccp_two_output;
        logic single_ccp_three_event;
        logic adc_end_of_conversion;
        logic uart_one_tx;
        logic uart_two_tx;
        logic spi_two_sdo;
    } lcig_event_t;

    localparam int ASYNC_W = $bits(lcig_async_t);
endpackage : lcig_pkg

// file: src/lcig_gate.sv
`timescale 1ns/100ps
module lcig_gate (
    input wire logic [3:0] data,
    input wire logic [31:0] enables,
    input wire logic [3:0] invert,
    input wire logic enable,
    output logic [3:0] gate
);
    import lcig_pkg::*;

    // ==========================================================
    // Gate matrix: per gate, OR of enabled true and inverted forms
    // ==========================================================
    always_comb begin
        logic acc;
        acc = 1'b0;
        gate = 4'h0;
        for (int g = 0; g < 4; g++) begin
            acc = 1'b0;
            for (int y = 0; y < 4; y++) begin
                // True form sits above inverted form
                acc = acc | (enables[g*GATE_BYTE_W + 2*y + 1] & data[y]);
                acc = acc | (enables[g*GATE_BYTE_W + 2*y] & ~data[y]);
            end
            // Cleared bits add nothing, so no bits gives the gate polarity bit, zero when it is clear
            gate[g] = enable & (acc ^ invert[g]);
        end
    end
endmodule : lcig_gate

// file: test/lcig_src_model.sv
`timescale 1ns/100ps
module lcig_src_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire lcig_pkg::lcig_async_t want_async,
    input wire lcig_pkg::lcig_event_t want_event,
    output lcig_pkg::lcig_async_t src_async,
    output lcig_pkg::lcig_event_t src_event
);
    import lcig_pkg::*;
    // ==========================================================
    // Peripheral and pin levels, changed only on hclk edges
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_async <= '0;
            src_event <= '0;
        end else begin
            src_async <= want_async;
            src_event <= want_event;
        end
    end
endmodule : lcig_src_model

// file: test/test_logic_cell_input_gating.sv
`timescale 1ns/100ps
module test_logic_cell_input_gating;
    import lcig_pkg::*;
    localparam int EV_W = $bits(lcig_event_t);
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    lcig_async_t want_async = '0;
    lcig_event_t want_event = '0;
    lcig_async_t src_async;
    lcig_event_t src_event;
    logic [7:0] gate_out;
    logic [1:0] cell_out;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    assign hready = hreadyout;

    lcig_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .src_async(src_async),
        .src_event(src_event), .gate_out(gate_out), .cell_out(cell_out));
    lcig_src_model u_src (.hclk(hclk), .hresetn(hresetn),
        .want_async(want_async), .want_event(want_event),
        .src_async(src_async), .src_event(src_event));

    initial begin
        forever #5 hclk = ~hclk;
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            results;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= TRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd_chk

    task automatic settle;
        repeat (6) @(posedge hclk);
        #1;
    endtask : settle

    function automatic logic [31:0] em(input int k);
        return 32'h1 << (EV_W - 1 - k);
    endfunction : em

    function automatic logic [31:0] am(input int k);
        return 32'h1 << (ASYNC_W - 1 - k);
    endfunction : am

    // Target field alone high, then all but the target high
    task automatic chk_src(input int c, input int s, input logic [2:0] code,
                           input bit as, input logic [31:0] m,
                           input logic e);
        logic [7:0] b;
        b = (c == 1) ? CELL_STRIDE : 8'h00;
        wr(b + SEL_OFS, {29'h0, code} << (4 * s));
        wr(b + GLS_OFS, 32'h1 << (2 * s + 1 + 24 * c));
        wr(b + CTRL_OFS, 32'h1 << CTRL_EN_BIT);
        @(posedge hclk);
        want_async <= as ? m[ASYNC_W-1:0] : '0;
        want_event <= as ? '0 : m[EV_W-1:0];
        settle;
        chk({31'h0, gate_out[7 * c]}, {31'h0, e});
        @(posedge hclk);
        want_async <= as ? ~m[ASYNC_W-1:0] : '1;
        want_event <= as ? '1 : ~m[EV_W-1:0];
        settle;
        chk({31'h0, gate_out[7 * c]}, 32'h0);
    endtask : chk_src

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs;
        logic [7:0] a[6];
        a = '{CTRL1_ADDR, SEL1_ADDR, GLS1_ADDR, CTRL2_ADDR, SEL2_ADDR,
              GLS2_ADDR};
        foreach (a[i]) begin
            rd_chk(a[i], 32'h0);
        end
        wr(GLS2_ADDR, 32'hA5A5_5A5A);
        rd_chk(GLS2_ADDR, 32'hA5A5_5A5A);
        wr(SEL2_ADDR, 32'hFFFF_FFFF);
        rd_chk(SEL2_ADDR, SEL_MASK);
        wr(8'h40, 32'hFFFF_FFFF);
        rd_chk(8'h40, 32'h0);
        wr(GLS2_ADDR, 32'h0);
        wr(SEL2_ADDR, 32'h0);
    endtask : t_regs

    // Source one on multi_ccp_output_a, source four unmapped and so zero
    task automatic t_gates;
        logic e;
        logic [3:0] n;
        wr(SEL1_ADDR, {29'h0, CODE_5});
        wr(CTRL1_ADDR, 32'h1 << CTRL_EN_BIT);
        for (int g = 0; g < 4; g++) begin
            for (int f = 0; f < 4; f++) begin
                wr(GLS1_ADDR, 32'h1 << (8 * g + ((f < 2) ? 1 - f : 9 - f)));
                for (int v = 0; v < 2; v++) begin
                    @(posedge hclk);
                    want_async <= '0;
                    want_event <= v[0] ? em(1) : '0;
                    settle;
                    e = (f == 0) ? v[0] : (f == 1) ? !v[0] : (f == 3);
                    n = {3'h0, e} << g;
                    chk(32'(gate_out[3:0]), 32'(n));
                    chk({31'h0, cell_out[0]}, {31'h0, e});
                end
            end
        end
    endtask : t_gates

    task automatic t_codes;
        logic [31:0] pa;
        logic [31:0] pb;
        pa = am(0) | am(1);
        pb = am(2) | am(3);
        chk_src(0, 0, CODE_7, 1'b0, em(3), 1'b1);
        chk_src(0, 0, CODE_6, 1'b0, em(2), 1'b1);
        chk_src(0, 0, CODE_5, 1'b0, em(1), 1'b1);
        chk_src(0, 0, CODE_4, 1'b1, am(4), 1'b1);
        chk_src(0, 0, CODE_3, 1'b1, am(5), 1'b1);
        chk_src(0, 0, CODE_2, 1'b1, am(6), 1'b1);
        chk_src(0, 0, CODE_0, 1'b1, pa, 1'b1);
        chk_src(1, 0, CODE_5, 1'b0, em(1), 1'b1);
        chk_src(0, 1, CODE_6, 1'b0, em(0), 1'b1);
        chk_src(0, 1, CODE_4, 1'b0, em(7), 1'b1);
        chk_src(0, 1, CODE_3, 1'b0, em(8), 1'b1);
        chk_src(0, 1, CODE_2, 1'b1, am(7), 1'b1);
        chk_src(0, 1, CODE_0, 1'b1, pb, 1'b1);
        chk_src(0, 1, CODE_7, 1'b0, 32'hFFFF_FFFF, 1'b0);
        chk_src(0, 1, CODE_5, 1'b0, 32'hFFFF_FFFF, 1'b0);
        chk_src(1, 1, CODE_6, 1'b0, em(0), 1'b1);
        chk_src(1, 1, CODE_4, 1'b0, em(7), 1'b1);
        chk_src(1, 1, CODE_3, 1'b0, em(9), 1'b1);
        chk_src(1, 1, CODE_2, 1'b1, am(7), 1'b1);
        chk_src(1, 1, CODE_0, 1'b1, pb, 1'b1);
        chk_src(1, 1, CODE_5, 1'b0, 32'hFFFF_FFFF, 1'b0);
        chk_src(1, 2, CODE_7, 1'b0, em(6), 1'b1);
        chk_src(1, 2, CODE_6, 1'b0, em(4), 1'b1);
        chk_src(1, 2, CODE_5, 1'b0, em(5), 1'b1);
        chk_src(1, 2, CODE_4, 1'b1, am(9), 1'b1);
        chk_src(1, 2, CODE_3, 1'b0, em(10), 1'b1);
        chk_src(1, 2, CODE_2, 1'b1, am(8), 1'b1);
        chk_src(1, 2, CODE_0, 1'b1, pa, 1'b1);
    endtask : t_codes

    // Own output holds itself, then other cell and system clock as sources
    task automatic t_cross;
        logic p;
        wr(SEL2_ADDR, {21'h0, CODE_1, 8'h00});
        wr(GLS2_ADDR, 32'h0000_0020);
        wr(CTRL2_ADDR, (32'h1 << CTRL_EN_BIT) | (32'h2 << CTRL_POL_LSB));
        wr(CTRL2_ADDR, 32'h1 << CTRL_EN_BIT);
        wr(SEL1_ADDR, {25'h0, CODE_1, 1'b0, CODE_1});
        wr(GLS1_ADDR, 32'h0000_0008);
        wr(CTRL1_ADDR, 32'h1 << CTRL_EN_BIT);
        settle;
        chk({31'h0, gate_out[4]}, 32'h1);
        chk({31'h0, gate_out[0]}, 32'h1);
        wr(CTRL2_ADDR, 32'h0);
        settle;
        chk({30'h0, gate_out[4], gate_out[0]}, 32'h0);
        wr(GLS1_ADDR, 32'h0000_0002);
        settle;
        p = gate_out[0];
        @(posedge hclk);
        #1;
        chk({31'h0, gate_out[0]}, {31'h0, !p});
    endtask : t_cross

    task automatic t_ctrl;
        wr(GLS1_ADDR, 32'h0);
        wr(CTRL1_ADDR, (32'h1 << CTRL_EN_BIT) | (32'h4 << CTRL_POL_LSB));
        settle;
        chk({28'h0, gate_out[3:0]}, 32'h4);
        chk({31'h0, cell_out[0]}, 32'h1);
        wr(GLS1_ADDR, 32'h0000_0300);
        wr(CTRL1_ADDR, 32'h1 << CTRL_EN_BIT);
        settle;
        chk({28'h0, gate_out[3:0]}, 32'h2);
        wr(CTRL1_ADDR, 32'h4 << CTRL_POL_LSB);
        settle;
        chk({28'h0, gate_out[3:0]}, 32'h0);
        chk({31'h0, cell_out[0]}, 32'h0);
    endtask : t_ctrl

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_gates;
        t_codes;
        t_cross;
        t_ctrl;
        results;
    end
endmodule : test_logic_cell_input_gating
